// File: verilog/mip_top.v
`include "mip_consts.vh"

module mip_top (
    input  wire        sys_clk_in,                // core clock, 20 mhz
    input  wire        sys_rst_in,                // sync reset, high
    input  wire [15:0] reg_addr_in,               // register address
    input  wire [31:0] reg_wdata_in,              // write data
    input  wire        reg_wr_in,                 // write strobe
    input  wire        reg_rd_in,                 // read strobe
    output wire [31:0] reg_rdata_out,             // read data, next cycle
    input  wire        reset_done_in,             // reset complete pulse
    input  wire [2:0]  total_idle_in,             // total power idle per phase
    input  wire [2:0]  fund_idle_in,              // fundamental idle per phase
    input  wire [2:0]  apparent_idle_in,          // apparent idle per phase
    input  wire [11:0] zx_event_in,               // crossing events, flags 14:3
    input  wire [2:0]  dip_phase_in,              // dip pulse per phase
    input  wire [2:0]  oc_phase_in,               // overcurrent pulse per phase
    input  wire [2:0]  ov_phase_in,               // overvoltage pulse per phase
    input  wire        va_rise_in,                // phase a voltage rising cross
    input  wire        vb_rise_in,                // phase b voltage rising cross
    input  wire        vc_rise_in,                // phase c voltage rising cross
    input  wire        sample_valid_in,           // current samples valid
    input  wire [31:0] summed_phase_current_in,   // signed phase sum
    input  wire [31:0] neutral_current_sample_in, // signed neutral current
    input  wire        pk_i_end_in,               // current peak period ended
    input  wire        pk_v_end_in,               // voltage peak period ended
    input  wire        checksum_valid_in,         // new checksum present
    input  wire [31:0] checksum_in,               // latest checksum
    output wire        irq_out                    // interrupt request, high
);

    // ****************************************
    // state machine codes for phase order
    // ****************************************
    localparam SEQ_IDLE  = 1'b0;
    localparam SEQ_SAW_A = 1'b1;

    // ****************************************
    // declarations
    // ****************************************
    reg  [31:0] interrupt_enable_second;
    reg  [31:0] mismatch_threshold;
    reg         run_control;
    reg  [31:0] run_checksum;
    reg  [31:0] rdata;
    reg         irq;
    reg  [8:0]  no_load_state;
    reg         seq_state;
    reg         next_seq_state;
    reg         seq_error;
    reg         mismatch_event;
    reg         crc_event;
    reg  [31:0] next_rdata;

    wire        wr_enable;
    wire        wr_flags;
    wire        wr_threshold;
    wire        wr_run;
    wire [31:0] flags_clr;
    wire [31:0] flags_set;
    wire [31:0] event_flags_second;
    wire [8:0]  phase_clr;
    wire [8:0]  phase_set;
    wire [8:0]  phase_bits;
    wire [2:0]  overcurrent_phase_bits;
    wire [2:0]  overvoltage_phase_bits;
    wire [2:0]  dip_phase_bits;
    wire [2:0]  total_idle_phase_bits;
    wire [2:0]  fundamental_idle_phase_bits;
    wire [2:0]  apparent_idle_phase_bits;
    wire        total_idle_flag;
    wire        fundamental_idle_flag;
    wire        apparent_idle_flag;
    wire [15:0] phase_event_source;
    wire [15:0] phase_no_load_state;
    wire [32:0] current_diff;
    wire [32:0] current_mag;
    wire [31:0] pending;

    // ****************************************
    // address decode
    // ****************************************

    // writes are single cycle strobes; unmapped writes fall away
    assign wr_enable    = reg_wr_in && (reg_addr_in == `MIP_ADDR_ENABLE);
    assign wr_flags     = reg_wr_in && (reg_addr_in == `MIP_ADDR_FLAGS);
    assign wr_threshold = reg_wr_in && (reg_addr_in == `MIP_ADDR_THRESHOLD);
    assign wr_run       = reg_wr_in && (reg_addr_in == `MIP_ADDR_RUN);

    // ****************************************
    // enable, threshold and run registers
    // ****************************************

    // reserved enable bits are never stored, so they stay zero and steer nothing
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            interrupt_enable_second <= `MIP_ENABLE_RESET;     // R21
        end else if (wr_enable) begin
            interrupt_enable_second <= reg_wdata_in & `MIP_ENABLE_MASK; // R11
        end
    end

    // mismatch threshold is an unsigned magnitude
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            mismatch_threshold <= `MIP_THRESHOLD_RESET;
        end else if (wr_threshold) begin
            mismatch_threshold <= reg_wdata_in;
        end
    end

    // the reference checksum is caught when run goes from 0 to 1
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            run_control  <= 1'b0;
            run_checksum <= 32'h00000000;
        end else if (wr_run) begin
            run_control <= reg_wdata_in[0];
            if (reg_wdata_in[0] && !run_control) begin
                run_checksum <= checksum_in;               // R10
            end
        end
    end

    // ****************************************
    // no-load phase state
    // ****************************************

    // level view of the idle inputs, one cycle behind them
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            no_load_state <= `MIP_PHASE_RESET;             // R21
        end else begin
            no_load_state <= {apparent_idle_in, fund_idle_in, total_idle_in};
        end
    end

    assign total_idle_phase_bits       = no_load_state[2:0]; // R16
    assign fundamental_idle_phase_bits = no_load_state[5:3]; // R17
    assign apparent_idle_phase_bits    = no_load_state[8:6]; // R18

    // a status flag is raised when any phase newly enters idle, so it
    // lands in the same cycle as the phase bit that caused it
    assign total_idle_flag       = |(total_idle_in & ~total_idle_phase_bits);    // R16
    assign fundamental_idle_flag = |(fund_idle_in & ~fundamental_idle_phase_bits); // R17
    assign apparent_idle_flag    = |(apparent_idle_in & ~apparent_idle_phase_bits); // R18

    // reserved bits tied low
    assign phase_no_load_state = {7'h00, no_load_state};  // R15

    // ****************************************
    // phase order checker
    // ****************************************

    // after a rising a, a rising c before b is an order fault; a fresh a
    // restarts the watch so only the nearest following crossing counts
    always @* begin
        next_seq_state = seq_state;
        case (seq_state)
            SEQ_IDLE: begin
                if (va_rise_in) begin
                    next_seq_state = SEQ_SAW_A;
                end
            end
            SEQ_SAW_A: begin
                if (vb_rise_in || vc_rise_in) begin
                    next_seq_state = va_rise_in ? SEQ_SAW_A : SEQ_IDLE;
                end
            end
            default: begin
                next_seq_state = SEQ_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            seq_state <= SEQ_IDLE;
            seq_error <= 1'b0;
        end else begin
            seq_state <= next_seq_state;
            seq_error <= (seq_state == SEQ_SAW_A) && vc_rise_in && !vb_rise_in; // R06
        end
    end

    // ****************************************
    // current mismatch detector
    // ****************************************

    // sign-extended difference cannot overflow in 33 bits
    assign current_diff = {summed_phase_current_in[31], summed_phase_current_in}
                        - {neutral_current_sample_in[31], neutral_current_sample_in};
    assign current_mag  = current_diff[32] ? (33'h000000000 - current_diff)
                                           : current_diff;

    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            mismatch_event <= 1'b0;
        end else begin
            mismatch_event <= sample_valid_in
                           && (current_mag > {1'b0, mismatch_threshold}); // R07
        end
    end

    // ****************************************
    // checksum watch
    // ****************************************

    // only meaningful while run is set; before that no reference exists
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            crc_event <= 1'b0;
        end else begin
            crc_event <= checksum_valid_in && run_control
                      && (checksum_in != run_checksum);    // R10
        end
    end

    // ****************************************
    // event flags
    // ****************************************

    // write one to clear; hardware set still wins in the same cycle
    assign flags_clr = wr_flags ? (reg_wdata_in & `MIP_ENABLE_MASK) : 32'h00000000;

    assign flags_set = {6'h00,
                        crc_event,                          // R10
                        pk_v_end_in,                        // R09
                        pk_i_end_in,                        // R08
                        2'b00,
                        mismatch_event,                     // R07
                        seq_error,                          // R06
                        |ov_phase_in,                       // R05
                        |oc_phase_in,                       // R04
                        |dip_phase_in,                      // R03
                        reset_done_in,
                        zx_event_in,                        // R01
                        apparent_idle_flag,
                        fundamental_idle_flag,
                        total_idle_flag};                   // R19

    mip_sticky #(
        .WIDTH (32)
    ) u_flags (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .set_in     (flags_set),
        .clr_in     (flags_clr),
        .q_out      (event_flags_second)
    );

    // ****************************************
    // phase event source
    // ****************************************

    // per-phase sources are held until software clears the summary flag
    assign phase_set = {dip_phase_in, ov_phase_in, oc_phase_in}; // R12 R13 R14
    assign phase_clr = {{3{flags_clr[`MIP_BIT_DIP]}},
                        {3{flags_clr[`MIP_BIT_OVERVOLTAGE]}},
                        {3{flags_clr[`MIP_BIT_OVERCURRENT]}}};

    mip_sticky #(
        .WIDTH (9)
    ) u_phase (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .set_in     (phase_set),
        .clr_in     (phase_clr),
        .q_out      (phase_bits)
    );

    assign overcurrent_phase_bits = phase_bits[2:0];     // R12
    assign overvoltage_phase_bits = phase_bits[5:3];     // R13
    assign dip_phase_bits         = phase_bits[8:6];     // R14

    // reserved positions read zero
    assign phase_event_source = {1'b0, dip_phase_bits, overvoltage_phase_bits,
                                 3'b000, overcurrent_phase_bits, 3'b000}; // R15

    // ****************************************
    // interrupt request
    // ****************************************

    // enable bit 15 is stored but ignored; reset-complete always passes
    assign pending = event_flags_second
                   & ((interrupt_enable_second & ~`MIP_RESET_DONE_MASK)
                      | `MIP_RESET_DONE_MASK);              // R02

    // registered so the pin carries no decode glitches
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            irq <= 1'b0;
        end else begin
            irq <= |pending;                                // R20
        end
    end

    assign irq_out = irq;

    // ****************************************
    // read path
    // ****************************************

    // unmapped addresses and idle cycles read as zero
    always @* begin
        next_rdata = 32'h00000000;
        if (reg_rd_in) begin
            if (reg_addr_in == `MIP_ADDR_ENABLE) begin
                next_rdata = interrupt_enable_second;
            end else if (reg_addr_in == `MIP_ADDR_FLAGS) begin
                next_rdata = event_flags_second;
            end else if (reg_addr_in == `MIP_ADDR_THRESHOLD) begin
                next_rdata = mismatch_threshold;
            end else if (reg_addr_in == `MIP_ADDR_RUN) begin
                next_rdata = {31'h00000000, run_control};
            end else if (reg_addr_in == `MIP_ADDR_PHASE_EVENT) begin
                next_rdata = {16'h0000, phase_event_source};
            end else if (reg_addr_in == `MIP_ADDR_NO_LOAD) begin
                next_rdata = {16'h0000, phase_no_load_state};
            end
        end
    end

    // data stand only in the cycle after the read strobe
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign reg_rdata_out = rdata;

endmodule

// File: include/mip_consts.vh
// How it works
// [R01] bit 14 enables phase C current crossing
// [R02] bit 15 writable, reset-complete never masked
// [R03] bit 16 enables dip, phases in 14:12
// [R04] bit 17 enables overcurrent, phases in 5:3
// [R05] bit 18 enables overvoltage, phases in 11:9
// [R06] bit 19 enables A-then-C order error
// [R07] bit 20 enables current mismatch over threshold
// [R08] bit 23 enables current peak period end
// [R09] bit 24 enables voltage peak period end
// [R10] bit 25 enables checksum change since run
// [R11] reserved enable bits reset zero, inert
// [R12] bits 3..5 mark overcurrent source phase
// [R13] bits 9..11 mark overvoltage source phase
// [R14] bits 12..14 mark dip source phase
// [R15] reserved phase register bits read zero
// [R16] bits 0..2 show total-power idle phases
// [R17] bits 3..5 show fundamental idle phases
// [R18] bits 6..8 show apparent idle phases
// [R19] bit 0 enables total idle entry
// [R20] flag and enable raise request; reset-complete always
// [R21] enables and phase bits reset to zero
`ifndef MIP_CONSTS_VH
`define MIP_CONSTS_VH

// ****************************************
// register offsets
// ****************************************
`define MIP_ADDR_ENABLE       16'he50b
`define MIP_ADDR_FLAGS        16'he50d
`define MIP_ADDR_THRESHOLD    16'he510
`define MIP_ADDR_RUN          16'he520
`define MIP_ADDR_PHASE_EVENT  16'he600
`define MIP_ADDR_NO_LOAD      16'he608

// ****************************************
// event flag bit positions
// ****************************************
`define MIP_BIT_TOTAL_IDLE    0
`define MIP_BIT_RESET_DONE    15
`define MIP_BIT_DIP           16
`define MIP_BIT_OVERCURRENT   17
`define MIP_BIT_OVERVOLTAGE   18

// ****************************************
// masks and reset values
// ****************************************
`define MIP_ENABLE_MASK       32'h039fffff
`define MIP_RESET_DONE_MASK   32'h00008000
`define MIP_ENABLE_RESET      32'h00000000
`define MIP_FLAGS_RESET       32'h00000000
`define MIP_PHASE_RESET       9'h000
`define MIP_THRESHOLD_RESET   32'h00000000

`endif

// File: verilog/mip_sticky.v
// ****************************************
// sticky flag vector, set wins over clear
// ****************************************
module mip_sticky #(
    parameter WIDTH = 8
) (
    input  wire             sys_clk_in, // core clock
    input  wire             sys_rst_in, // sync reset, high
    input  wire [WIDTH-1:0] set_in,     // hardware event pulses
    input  wire [WIDTH-1:0] clr_in,     // clear requests
    output wire [WIDTH-1:0] q_out       // held flags
);

    reg  [WIDTH-1:0] q;
    wire [WIDTH-1:0] next_q;

    // an event in the clearing cycle must survive, so set is ored last
    assign next_q = (q & ~clr_in) | set_in;

    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            q <= {WIDTH{1'b0}};
        end else begin
            q <= next_q;
        end
    end

    assign q_out = q;

endmodule

// File: test/mip_properties.sv
`include "mip_consts.vh"

// ****************************************
// port-level checks of the enable and phase registers and of the interrupt request
// ****************************************
module mip_top_checker (
    input logic        sys_clk_in,       // core clock
    input logic        sys_rst_in,       // sync reset
    input logic [15:0] reg_addr_in,      // address
    input logic [31:0] reg_wdata_in,     // write data
    input logic        reg_wr_in,        // write strobe
    input logic        reg_rd_in,        // read strobe
    input logic [31:0] reg_rdata_out,    // read data
    input logic        reset_done_in,    // reset-complete pulse
    input logic [2:0]  total_idle_in,    // total idle levels
    input logic [2:0]  fund_idle_in,     // fundamental idle levels
    input logic [2:0]  apparent_idle_in, // apparent idle levels
    input logic [2:0]  dip_phase_in,     // dip pulses
    input logic [2:0]  oc_phase_in,      // overcurrent pulses
    input logic [2:0]  ov_phase_in,      // overvoltage pulses
    input logic        irq_out           // request
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    logic en_oc;
    wire       rd_ev   = reg_rd_in && reg_addr_in == `MIP_ADDR_PHASE_EVENT;
    wire       rd_nl   = reg_rd_in && reg_addr_in == `MIP_ADDR_NO_LOAD;
    wire       rd_en   = reg_rd_in && reg_addr_in == `MIP_ADDR_ENABLE;
    wire       wr_en   = reg_wr_in && reg_addr_in == `MIP_ADDR_ENABLE;
    wire [8:0] idle_lv = {apparent_idle_in, fund_idle_in, total_idle_in};
    // shadow of the overcurrent enable, so the request can be tied to it
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            en_oc <= 1'b0;
        end else if (wr_en) begin
            en_oc <= reg_wdata_in[17];
        end
    end
    a_oc_phase_mark: assert property (
        |oc_phase_in ##2 rd_ev |=> &(reg_rdata_out[5:3] | ~$past(oc_phase_in, 3)))
        else $error("overcurrent phase bit missing");
    a_ov_phase_mark: assert property (
        |ov_phase_in ##2 rd_ev |=> &(reg_rdata_out[11:9] | ~$past(ov_phase_in, 3)))
        else $error("overvoltage phase bit missing");
    a_dip_phase_mark: assert property (
        |dip_phase_in ##2 rd_ev |=> &(reg_rdata_out[14:12] | ~$past(dip_phase_in, 3)))
        else $error("dip phase bit missing");
    a_phase_reserved_zero: assert property (
        rd_ev |=> (reg_rdata_out & 32'hffff81c7) == 32'h0)
        else $error("reserved phase bits set");
    a_idle_state_view: assert property (
        rd_nl && $stable(idle_lv) |=> reg_rdata_out == {23'h0, $past(idle_lv)})
        else $error("no-load bits wrong");
    a_enable_read_back: assert property (
        wr_en ##2 rd_en |=> reg_rdata_out == ($past(reg_wdata_in, 3) & `MIP_ENABLE_MASK))
        else $error("enable read back wrong");
    a_reset_done_irq: assert property (
        reset_done_in |-> ##[2:3] irq_out)
        else $error("reset-complete did not raise request");
    a_oc_irq_raise: assert property (
        |oc_phase_in && en_oc |-> ##[2:3] irq_out)
        else $error("enabled overcurrent did not raise request");
    cover property ($rose(irq_out));
    cover property (rd_nl ##1 reg_rdata_out != 32'h0);
    cover property (wr_en ##2 rd_en);
endmodule

// File: test/mip_top_tb_top.sv
`include "mip_consts.vh"

module mip_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic [15:0] addr = 16'h0;
    logic [31:0] wdata = 32'h0, sum = 32'h0, neut = 32'h0, csum = 32'h0;
    logic        wr = 1'b0, rd = 1'b0, irq;
    logic [28:0] ev = 29'h0; // one-cycle event pulses, sliced onto the inputs
    logic [8:0]  lv = 9'h0;  // idle levels, same layout as the no-load register
    logic [31:0] rdata, m_en = 32'h0, m_fl = 32'h0, m_ph = 32'h0, seed = 32'h5375;
    logic [2:0]  p;
    int          sh, err_total = 0, n_compared = 0, cyc = 0;
    mip_top dut_u (
        .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .reset_done_in(ev[2]), .total_idle_in(lv[2:0]), .fund_idle_in(lv[5:3]),
        .apparent_idle_in(lv[8:6]), .zx_event_in(ev[14:3]), .dip_phase_in(ev[17:15]),
        .oc_phase_in(ev[20:18]), .ov_phase_in(ev[23:21]), .va_rise_in(ev[24]),
        .vb_rise_in(ev[25]), .vc_rise_in(ev[26]), .sample_valid_in(ev[1]),
        .summed_phase_current_in(sum), .neutral_current_sample_in(neut),
        .pk_i_end_in(ev[27]), .pk_v_end_in(ev[28]), .checksum_valid_in(ev[0]),
        .checksum_in(csum), .irq_out(irq));
    // ****************************************
    // clock, watchdog and helpers
    // ****************************************
    always #25 sys_clk_in = ~sys_clk_in;
    // the whole run needs about 1100 cycles; a hang stops well past that
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            err_total++;
            conclude();
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_in);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so look there
    task automatic rreg(input logic [15:0] a, input logic [31:0] exp);
        @(posedge sys_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_in);
        rd <= 1'b0;
        @(negedge sys_clk_in);
        chk(rdata, exp);
    endtask
    task automatic pulse(input logic [28:0] v);
        @(posedge sys_clk_in);
        ev <= v;
        @(posedge sys_clk_in);
        ev <= 29'h0;
    endtask
    // the phase, no-load, flag and enable registers and the request against the model
    task automatic chkall();
        rreg(`MIP_ADDR_PHASE_EVENT, m_ph);
        rreg(`MIP_ADDR_NO_LOAD, {23'h0, lv});
        rreg(`MIP_ADDR_FLAGS, m_fl);
        rreg(`MIP_ADDR_ENABLE, m_en);
        chk({31'h0, irq}, {31'h0, |(m_fl & (m_en | `MIP_RESET_DONE_MASK))});
    endtask
    // makes the source of flag b fire once, phases picked at random
    task automatic cause(input int b, output logic [2:0] ph);
        logic [31:0] t;
        ph = 3'(rnd() % 7 + 1);
        t = rnd() & 32'hffff;
        case (b)
            0, 1, 2: lv <= 9'({6'h0, ph} << (3 * b));
            15: pulse(29'h4);
            16: pulse({11'h0, ph, 15'h0});
            17: pulse({8'h0, ph, 18'h0});
            18: pulse({5'h0, ph, 21'h0});
            19: begin
                pulse(29'h1 << 24);
                pulse(29'h1 << 25);
                pulse(29'h1 << 24);
                pulse(29'h1 << 26);
            end
            20: begin
                wreg(`MIP_ADDR_THRESHOLD, t);
                rreg(`MIP_ADDR_THRESHOLD, t);
                sum <= t;
                pulse(29'h2);
                sum <= 32'h0;
                neut <= t + 32'h1;
                rreg(`MIP_ADDR_FLAGS, m_fl);
                pulse(29'h2);
            end
            23: pulse(29'h1 << 27);
            24: pulse(29'h1 << 28);
            25: begin
                csum <= t;
                wreg(`MIP_ADDR_RUN, 32'h1);
                csum <= ~t;
                rreg(`MIP_ADDR_RUN, 32'h1);
                pulse(29'h1);
                wreg(`MIP_ADDR_RUN, 32'h0);
            end
            default: pulse(29'h1 << b);
        endcase
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (6) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        chkall();
        rreg(16'he700, 32'h0);
        for (int i = 0; i < 5; i++) begin
            m_en = (i == 0) ? 32'hffffffff : rnd();
            wreg(`MIP_ADDR_ENABLE, m_en);
            rreg(`MIP_ADDR_ENABLE, m_en & `MIP_ENABLE_MASK);
        end
        // each flag once enabled alone and once disabled with all others enabled
        for (int b = 0; b < 26; b++) begin
            if (b == 21 || b == 22) continue;
            sh = (b == 16) ? 12 : (b == 17) ? 3 : 9;
            for (int m = 0; m < 2; m++) begin
                m_en = m ? (32'h1 << b) : (`MIP_ENABLE_MASK & ~(32'h1 << b));
                wreg(`MIP_ADDR_ENABLE, m_en);
                cause(b, p);
                m_fl[b] = 1'b1;
                if (b inside {[16:18]}) m_ph |= {29'h0, p} << sh;
                chkall();
                wreg(`MIP_ADDR_FLAGS, 32'h1 << b);
                m_fl[b] = 1'b0;
                if (b inside {[16:18]}) m_ph &= ~(32'h7 << sh);
                lv <= 9'h0;
                chkall();
            end
        end
        conclude();
    end
endmodule

bind mip_top mip_top_checker chk_u (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .reset_done_in(reset_done_in),
    .total_idle_in(total_idle_in), .fund_idle_in(fund_idle_in),
    .apparent_idle_in(apparent_idle_in), .dip_phase_in(dip_phase_in),
    .oc_phase_in(oc_phase_in), .ov_phase_in(ov_phase_in), .irq_out(irq_out));
